// >>> hw/zt_sram_array.sv
// storage array with per-lane write and a registered, write-first read port
// assumes write and read enables are already qualified by the clock enable
`timescale 1ns/1ps
`default_nettype none

module zt_sram_array #(
    parameter int AW = zt_sram_pkg::ADDR_W,
    parameter int NL = zt_sram_pkg::LANES
)
(
    // clock
    input wire logic i_sys_clk,
    // write port
    input wire logic i_wr_en,
    input wire logic [AW-1:0] i_wr_addr,
    input wire logic [NL-1:0] i_wr_lanes,
    input wire logic [zt_sram_pkg::WORD_W-1:0] i_wr_data,
    // read port
    input wire logic i_rd_en,
    input wire logic [AW-1:0] i_rd_addr,
    output logic [zt_sram_pkg::WORD_W-1:0] o_rd_data
);
    import zt_sram_pkg::*;

    // lane_merge works on the package lane count, so the port width must match it
    if (NL != LANES)
    begin : g_bad_cfg
        $error("zt_sram_array: unsupported lane count");
    end

    logic [WORD_W-1:0] mem [0:(1<<AW)-1];
    logic [WORD_W-1:0] rd_d;

    // write-first read: a write landing on the same edge must be seen, or a
    // read issued one cycle after a write to the same word would return stale data
    always_comb
    begin
        rd_d = o_rd_data;
        if (i_rd_en)
        begin
            rd_d = mem[i_rd_addr];
            if (i_wr_en && (i_wr_addr == i_rd_addr))
            begin
                rd_d = lane_merge(mem[i_rd_addr], i_wr_data, i_wr_lanes);
            end
        end
    end

    // no reset on the array itself: contents are undefined at power-up
    always_ff @(posedge i_sys_clk)
    begin
        o_rd_data <= rd_d;
        if (i_wr_en)
        begin
            mem[i_wr_addr] <= lane_merge(mem[i_wr_addr], i_wr_data, i_wr_lanes);
        end
    end

endmodule
`default_nettype wire

// >>> hw/zt_sram_port.sv
// synchronous pipelined zero-turnaround static memory port with 4-word bursts
// assumes the far-side controller drives all synchronous inputs from the same clock
`timescale 1ns/1ps
`default_nettype none

module zt_sram_port #(
    parameter int AW = zt_sram_pkg::ADDR_W,
    parameter int NL = zt_sram_pkg::LANES
)
(
    // clock and reset
    input wire logic i_sys_clk,
    input wire logic i_rst_n,
    // command
    input wire logic [AW-1:0] i_addr_in,
    input wire logic i_advance_or_load,
    input wire logic i_read_write,
    input wire logic i_clock_enable_n,
    input wire logic [NL-1:0] i_byte_write_n,
    input wire logic i_chip_select_a_n,
    input wire logic i_chip_select_b_n,
    input wire logic i_chip_select_hi,
    input wire logic i_burst_order_sel,
    input wire logic i_output_enable_n,
    // data bus, split into input, output and output enable
    input wire logic [31:0] i_data_io,
    input wire logic [NL-1:0] i_parity_io,
    output logic [31:0] o_data_io,
    output logic [NL-1:0] o_parity_io,
    output logic o_data_io_oe_n
);
    import zt_sram_pkg::*;

    // the lane packing below is written for exactly four 9-bit lanes
    if (NL != LANES || AW < BURST_CNT_W)
    begin : g_bad_cfg
        $error("zt_sram_port: unsupported lane count or address width");
    end

    // burst tracker
    burst_t burst_q, burst_d;
    logic [AW-1:0] base_q, base_d;
    logic [BURST_CNT_W-1:0] cnt_q, cnt_d;
    // stage 1: operation issued on the last enabled edge
    logic op_vld_q, op_vld_d;
    logic op_wr_q, op_wr_d;
    logic [AW-1:0] op_addr_q, op_addr_d;
    logic [NL-1:0] op_lanes_q, op_lanes_d;
    // stage 2: write waiting for its data, and read-data drive flag
    logic wr_vld_q, wr_vld_d;
    logic [AW-1:0] wr_addr_q, wr_addr_d;
    logic [NL-1:0] wr_lanes_q, wr_lanes_d;
    logic drive_q, drive_d;

    logic selected;
    logic stepping;
    logic [BURST_CNT_W-1:0] cnt_nx;
    logic [BURST_CNT_W-1:0] low_nx;
    logic [WORD_W-1:0] wr_word;
    logic [WORD_W-1:0] rd_word;

    // all three selects true; the two low-true ones are inverted
    assign selected = !i_chip_select_a_n && !i_chip_select_b_n && i_chip_select_hi;

    // next burst address bits: only the two lowest bits ever change
    assign cnt_nx = cnt_q + 2'h1;
    assign low_nx = i_burst_order_sel ? (base_q[BURST_CNT_W-1:0] ^ cnt_nx)
                                      : (base_q[BURST_CNT_W-1:0] + cnt_nx);
    // advance with a burst still under way and words left in it
    assign stepping = (burst_q != BURST_IDLE) && (cnt_q != BURST_LAST);

    // pack pins into 9-bit lanes: lane k = {parity k, data byte k}
    always_comb
    begin
        for (int k = 0; k < LANES; k++)
        begin
            wr_word[k*LANE_W +: LANE_W] = {i_parity_io[k], i_data_io[k*BYTE_W +: BYTE_W]};
        end
    end

    // command decode and pipeline advance
    always_comb
    begin
        burst_d = burst_q;
        base_d = base_q;
        cnt_d = cnt_q;
        op_vld_d = op_vld_q;
        op_wr_d = op_wr_q;
        op_addr_d = op_addr_q;
        op_lanes_d = op_lanes_q;
        wr_vld_d = wr_vld_q;
        wr_addr_d = wr_addr_q;
        wr_lanes_d = wr_lanes_q;
        drive_d = drive_q;
        // a high clock enable leaves every register as it was
        if (!i_clock_enable_n)
        begin
            op_vld_d = 1'b0;
            if (!i_advance_or_load)
            begin
                if (selected)
                begin
                    // load: new address and control start a fresh access
                    base_d = i_addr_in;
                    cnt_d = BURST_FIRST;
                    burst_d = i_read_write ? BURST_RD : BURST_WR;
                    op_vld_d = 1'b1;
                    op_wr_d = !i_read_write;
                    op_addr_d = i_addr_in;
                    op_lanes_d = i_read_write ? '0 : ~i_byte_write_n;
                end
                else
                begin
                    // deselect: no new access, running burst dropped
                    burst_d = BURST_IDLE;
                end
            end
            else
            begin
                // advance: external address is not looked at here
                case (burst_q)
                    BURST_RD, BURST_WR:
                    begin
                        if (stepping)
                        begin
                            cnt_d = cnt_nx;
                            op_vld_d = 1'b1;
                            op_wr_d = (burst_q == BURST_WR);
                            op_addr_d = {base_q[AW-1:BURST_CNT_W], low_nx};
                            // lane enables are taken fresh on each burst write beat
                            op_lanes_d = (burst_q == BURST_WR) ? ~i_byte_write_n : '0;
                        end
                        else
                        begin
                            burst_d = BURST_IDLE;
                        end
                    end
                    BURST_IDLE:
                    begin
                        burst_d = BURST_IDLE;
                    end
                    default:
                    begin
                        burst_d = BURST_IDLE;
                    end
                endcase
            end
            // stage 2 follows stage 1 regardless of the new command, so work
            // already in flight finishes even across a deselect
            wr_vld_d = op_vld_q && op_wr_q;
            wr_addr_d = op_addr_q;
            wr_lanes_d = op_lanes_q;
            // read data goes out one edge after issue, valid at the second edge;
            // writes and deselects release the bus on that same schedule
            drive_d = op_vld_q && !op_wr_q;
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            burst_q <= BURST_IDLE;
            base_q <= ADDR_RST[AW-1:0];
            cnt_q <= BURST_FIRST;
            op_vld_q <= 1'b0;
            op_wr_q <= 1'b0;
            op_addr_q <= ADDR_RST[AW-1:0];
            op_lanes_q <= '0;
            wr_vld_q <= 1'b0;
            wr_addr_q <= ADDR_RST[AW-1:0];
            wr_lanes_q <= '0;
            drive_q <= 1'b0;
        end
        else
        begin
            burst_q <= burst_d;
            base_q <= base_d;
            cnt_q <= cnt_d;
            op_vld_q <= op_vld_d;
            op_wr_q <= op_wr_d;
            op_addr_q <= op_addr_d;
            op_lanes_q <= op_lanes_d;
            wr_vld_q <= wr_vld_d;
            wr_addr_q <= wr_addr_d;
            wr_lanes_q <= wr_lanes_d;
            drive_q <= drive_d;
        end
    end

    // write on the second edge after the command, read on the first; the
    // array read register is the registered output path
    zt_sram_array #(
        .AW(AW),
        .NL(NL)
    ) u_array (
        .i_sys_clk(i_sys_clk),
        .i_wr_en(!i_clock_enable_n && wr_vld_q),
        .i_wr_addr(wr_addr_q),
        .i_wr_lanes(wr_lanes_q),
        .i_wr_data(wr_word),
        .i_rd_en(!i_clock_enable_n && op_vld_q && !op_wr_q),
        .i_rd_addr(op_addr_q),
        .o_rd_data(rd_word)
    );

    // unpack the read register onto the pins
    always_comb
    begin
        for (int k = 0; k < LANES; k++)
        begin
            o_data_io[k*BYTE_W +: BYTE_W] = rd_word[k*LANE_W +: BYTE_W];
            o_parity_io[k] = rd_word[k*LANE_W + BYTE_W];
        end
    end

    // output enable is the one path that bypasses the clock, so the bus can
    // be released at any moment without waiting for an edge
    assign o_data_io_oe_n = !drive_q || i_output_enable_n;

endmodule
`default_nettype wire

// >>> inc/zt_sram_pkg.sv
// constants, types and helpers shared by the zero-turnaround static memory port
// assumes a single rising-edge clock domain; no software-visible registers
package zt_sram_pkg;

    // array geometry: 128k words of four 9-bit lanes (8 data bits + 1 parity bit)
    localparam int ADDR_W = 17;
    localparam int LANES = 4;
    localparam int BYTE_W = 8;
    localparam int LANE_W = 9;
    localparam int WORD_W = 36;

    // burst geometry: four words, counter touches only the two low address bits
    localparam int BURST_CNT_W = 2;
    localparam logic [1:0] BURST_LAST = 2'h3;
    localparam logic [1:0] BURST_FIRST = 2'h0;

    // reset values of the pipeline registers; WORD_RST is unused, the output register has no reset
    localparam logic [WORD_W-1:0] WORD_RST = 36'h0;
    localparam logic [ADDR_W-1:0] ADDR_RST = 17'h0;

    // burst tracker states
    typedef enum logic [1:0]
    {
        BURST_IDLE = 2'b00,
        BURST_RD = 2'b01,
        BURST_WR = 2'b10
    } burst_t;

    // replace the lanes flagged in sel by the matching lanes of new_w
    function automatic logic [WORD_W-1:0] lane_merge(
        input logic [WORD_W-1:0] old_w,
        input logic [WORD_W-1:0] new_w,
        input logic [LANES-1:0] sel
    );
        logic [WORD_W-1:0] res;
        res = old_w;
        for (int k = 0; k < LANES; k++)
        begin
            if (sel[k])
            begin
                res[k*LANE_W +: LANE_W] = new_w[k*LANE_W +: LANE_W];
            end
        end
        return res;
    endfunction

endpackage

// >>> sim/tb_zt_sram_port.sv
// bench for the memory port: corner and random command streams against a word model
// assumes the port, its package, the controller model and the checker compile first
`timescale 1ns/1ps
`default_nettype none
module tb_zt_sram_port;
    import zt_sram_pkg::*;
    logic clk = 1'b0, rst_n = 1'b0, advance = 1'b0, rw = 1'b1, clk_en_n = 1'b0;
    logic oe_n = 1'b0, order, wr_beat = 1'b0, dev_oe_n;
    logic [2:0] sel = 3'h3;
    logic [16:0] addr = 17'h0;
    logic [3:0] bw_n = 4'h0, p1b, p2b, cb, p1a, p2a, ca, base, dev_par;
    logic [WORD_W-1:0] wdata = 36'h0, p1d, p2d, cd, bus;
    logic [WORD_W-1:0] mem [16];
    logic [31:0] dev_data;
    logic [1:0] n = 2'h0;
    int p1k = 0, p2k = 0, ck = 0, bk = 0, fails = 0, n_compared = 0;
    zt_sram_port i_zt_sram_port (
        .i_sys_clk(clk), .i_rst_n(rst_n), .i_addr_in(addr), .i_advance_or_load(advance),
        .i_read_write(rw), .i_clock_enable_n(clk_en_n), .i_byte_write_n(bw_n),
        .i_chip_select_a_n(sel[2]), .i_chip_select_b_n(sel[1]), .i_chip_select_hi(sel[0]),
        .i_burst_order_sel(order), .i_output_enable_n(oe_n), .i_data_io(bus[31:0]),
        .i_parity_io(bus[35:32]), .o_data_io(dev_data), .o_parity_io(dev_par),
        .o_data_io_oe_n(dev_oe_n));
    zt_sram_ctrl_model i_zt_sram_ctrl_model (.i_sys_clk(clk), .i_clk_en_n(clk_en_n),
        .i_wr_beat(wr_beat), .i_wdata(wdata), .i_dev_word({dev_par, dev_data}),
        .i_dev_oe_n(dev_oe_n), .o_bus(bus));
    // free-running clock, 8 ns period
    initial
    begin
        forever #4 clk = ~clk;
    end
    // lane k is data bits 8k..8k+7 plus parity bit k
    function automatic logic [35:0] merge(input logic [35:0] o, input logic [35:0] v,
        input logic [3:0] b);
        logic [35:0] m;
        m = 36'h0;
        for (int k = 0; k < 4; k++)
            m = m | (b[k] ? 36'h0 : (36'h0ff << (8 * k)) | (36'h1 << (32 + k)));
        return (o & ~m) | (v & m);
    endfunction
    task automatic check(input logic [35:0] seen, input logic [35:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            fails++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic complete_run();
        $display("compared %0d, mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    // one cycle: retire the model for the edge just passed, judge the pins, drive the next
    task automatic step(input logic a, input logic r, input logic [2:0] s, input logic c,
        input logic [16:0] ad, input logic [3:0] b, input logic [35:0] w);
        @(negedge clk);
        if (!clk_en_n)
        begin
            if (p2k == 2)
                mem[p2a] = merge(mem[p2a], p2d, p2b);
            {p2k, p2a, p2b, p2d} = {p1k, p1a, p1b, p1d};
            {p1k, p1a, p1b, p1d} = {ck, ca, cb, cd};
        end
        check(36'(dev_oe_n), 36'(p2k != 1 || oe_n));
        if (p2k == 1)
            check({dev_par, dev_data}, mem[p2a]);
        ck = 0;
        if (!c && !a)
        begin
            bk = (s != 3'h1) ? 0 : (r ? 1 : 2);
            base = ad[3:0];
            n = 2'h0;
            ck = bk;
        end
        else if (!c)
        begin
            ck = (bk != 0 && n != 2'h3) ? bk : 0;
            bk = ck;
            n = n + 2'(ck != 0);
        end
        ca = {base[3:2], order ? base[1:0] ^ n : base[1:0] + n};
        {cb, cd} = {b, w};
        {advance, rw, sel, clk_en_n, addr, bw_n, wdata} = {a, r, s, c, ad, b, w};
        wr_beat = (ck == 2);
    endtask
    task automatic do_reset(input logic ord);
        rst_n = 1'b0;
        // burst order only changes while the port is held in reset
        order = ord;
        repeat (10) @(negedge clk);
        rst_n = 1'b1;
        {p1k, p2k, ck, bk} = {32'h0, 32'h0, 32'h0, 32'h0};
    endtask
    // random mix incl. frozen edges, deselects and output enable toggles; ends drained
    task automatic rand_run(input int cycles);
        logic [2:0] s;
        for (int i = 0; i < cycles; i++)
        begin
            s = ($urandom % 2) ? 3'h1 : 3'($urandom);
            oe_n = ($urandom % 8 == 0);
            step(1'($urandom), 1'($urandom), s, $urandom % 8 == 0, 17'($urandom % 16),
                4'($urandom), {4'($urandom), $urandom});
        end
        oe_n = 1'b0;
        repeat (3) step(1'b0, 1'b1, 3'h3, 1'b0, 17'h0, 4'hf, 36'h0);
    endtask
    initial
    begin
        void'($urandom(81414));
        do_reset(1'b0);
        // whole-word fill with every lane enable held low
        for (int i = 0; i < 16; i++)
            step(1'b0, 1'b0, 3'h1, 1'b0, 17'(i), 4'h0, {4'($urandom), $urandom});
        // linear bursts with one advance past the fourth word, then advance after deselect
        for (int i = 0; i < 16; i += 5)
        begin
            step(1'b0, 1'b1, 3'h1, 1'b0, 17'(i), 4'h0, 36'h0);
            repeat (4) step(1'b1, 1'b0, 3'h1, 1'b0, 17'($urandom), 4'h0, 36'h0);
        end
        step(1'b0, 1'b1, 3'h6, 1'b0, 17'h0, 4'hf, 36'h0);
        step(1'b1, 1'b1, 3'h1, 1'b0, 17'h0, 4'hf, 36'h0);
        $display("test fill_burst done");
        rand_run(400);
        $display("test random_linear done");
        // switch to interleaved order, changed only while held in reset
        do_reset(1'b1);
        rand_run(400);
        $display("test random_interleaved done");
        complete_run();
    end
    // watchdog: the tests need about 900 cycles
    initial
    begin
        #40000;
        fails++;
        complete_run();
    end
endmodule
bind zt_sram_port zt_sram_port_monitor i_zt_sram_port_monitor (.i_sys_clk(i_sys_clk),
    .i_rst_n(i_rst_n), .i_advance_or_load(i_advance_or_load), .i_read_write(i_read_write),
    .i_clock_enable_n(i_clock_enable_n), .i_chip_select_a_n(i_chip_select_a_n),
    .i_chip_select_b_n(i_chip_select_b_n), .i_chip_select_hi(i_chip_select_hi),
    .i_output_enable_n(i_output_enable_n), .o_data_io(o_data_io),
    .o_data_io_oe_n(o_data_io_oe_n));
`default_nettype wire

// >>> sim/zt_sram_ctrl_model.sv
// far-side controller model: write data timing and the shared data bus
// assumes the bench hands it a write beat flag and a word each cycle
`timescale 1ns/1ps
`default_nettype none
module zt_sram_ctrl_model
(
    // clock and command from the bench
    input wire logic i_sys_clk,
    input wire logic i_clk_en_n,
    input wire logic i_wr_beat,
    input wire logic [35:0] i_wdata,
    // device drive and the resolved bus
    input wire logic [35:0] i_dev_word,
    input wire logic i_dev_oe_n,
    output logic [35:0] o_bus
);
    logic wr1_q = 1'b0, wr2_q = 1'b0;
    logic [35:0] wd1_q = 36'h0, wd2_q = 36'h0, last_q = 36'h0;
    // write word follows its command by two enabled edges, lanes valid on every beat
    always @(posedge i_sys_clk)
    begin
        last_q <= o_bus;
        if (!i_clk_en_n)
        begin
            wr1_q <= i_wr_beat;
            wd1_q <= i_wdata;
            wr2_q <= wr1_q;
            wd2_q <= wd1_q;
        end
    end
    // released bus shows the inverse of its last value so stale data never matches
    assign o_bus = wr2_q ? wd2_q : (!i_dev_oe_n ? i_dev_word : ~last_q);
endmodule
`default_nettype wire

// >>> sim/zt_sram_port_monitor.sv
// checker for the memory port: bus drive timing seen at the pins
// assumes a single clock; bound onto the port from the bench top
`timescale 1ns/1ps
`default_nettype none
module zt_sram_port_monitor
(
    // clock and reset
    input wire logic i_sys_clk,
    input wire logic i_rst_n,
    // command pins
    input wire logic i_advance_or_load,
    input wire logic i_read_write,
    input wire logic i_clock_enable_n,
    input wire logic i_chip_select_a_n,
    input wire logic i_chip_select_b_n,
    input wire logic i_chip_select_hi,
    input wire logic i_output_enable_n,
    // device side of the bus
    input wire logic [31:0] o_data_io,
    input wire logic o_data_io_oe_n
);
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (!i_rst_n);
    // all three selects true, the two low-true ones inverted
    wire logic sel = !i_chip_select_a_n && !i_chip_select_b_n && i_chip_select_hi;
    // only enabled edges count; a frozen edge must not advance the pipeline
    sequence s_run; !i_clock_enable_n; endsequence
    sequence s_step; !i_clock_enable_n && i_advance_or_load; endsequence
    sequence s_rd; !i_clock_enable_n && !i_advance_or_load && i_read_write && sel; endsequence
    sequence s_wr; !i_clock_enable_n && !i_advance_or_load && !i_read_write && sel; endsequence
    sequence s_off; !i_clock_enable_n && !i_advance_or_load && !sel; endsequence
    a_oe_forces_off: assert property (i_output_enable_n |-> o_data_io_oe_n)
        else $error("bus driven while output enable is high");
    a_read_drives: assert property (
        s_rd ##1 s_run |=> o_data_io_oe_n == i_output_enable_n)
        else $error("read word not driven two edges after load");
    a_write_quiet: assert property (s_wr ##1 s_run |=> o_data_io_oe_n)
        else $error("bus driven after a write load");
    a_desel_release: assert property (s_off ##1 s_run |=> o_data_io_oe_n)
        else $error("bus driven after a deselect");
    a_desel_drains: assert property (
        s_rd ##1 s_off |=> o_data_io_oe_n == i_output_enable_n)
        else $error("read in flight dropped by a deselect");
    a_burst_word: assert property (
        s_rd ##1 s_step ##1 s_run |=> o_data_io_oe_n == i_output_enable_n)
        else $error("second burst word not driven");
    a_step_idle: assert property (s_off ##1 s_step ##1 s_run |=> o_data_io_oe_n)
        else $error("advance after deselect drove the bus");
    a_burst_limit: assert property (s_rd ##1 s_step [*4] ##1 s_run |=> o_data_io_oe_n)
        else $error("burst ran past four words");
    a_freeze_hold: assert property (
        (i_clock_enable_n && !i_output_enable_n) ##1 !i_output_enable_n
            |-> $stable(o_data_io_oe_n) && $stable(o_data_io))
        else $error("outputs moved on a frozen edge");
endmodule
`default_nettype wire
